// ### dv/address_gpio_pin_mux_test.sv
`timescale 1ns/10ps
module address_gpio_pin_mux_test
    import agm_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, emi_bus_active = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [PA_W+PB_W-1:0] emi_addr = 12'h9A5;
    agm_strap_s strap = 3'b100;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [PA_W-1:0] pa_pin_in;
    logic [PB_W-1:0] pb_pin_in;
    agm_pad_a_s pad_a;
    agm_pad_b_s pad_b;
    int fail_count = 0, tests_run = 0;
    logic [7:0] rst_ofs [6] = '{OFS_PA_PULLUP, OFS_PA_DIR, OFS_PA_PERIPH, OFS_PB_PULLUP, OFS_PB_DIR, OFS_BUS_CTRL};
    logic [31:0] rst_val [6] = '{32'(RST_PA_PULLUP), 32'(RST_PA_DIR), 32'(RST_PA_PERIPH), 32'(RST_PB_PULLUP),
        32'(RST_PB_DIR), 32'(RST_ALWAYS_DRIVE)};
    agm_strap_s straps [3] = '{3'b010, 3'b011, 3'b000};
    logic [31:0] periph_exp [3] = '{32'hF, 32'h0, 32'h0};

    agm_pin_mux dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .emi_addr, .emi_bus_active,
        .strap, .pa_pin_in, .pb_pin_in, .pad_a, .pad_b);
    agm_ext_mem mem (.pad_a, .pad_b, .pa_pin_in, .pb_pin_in);

    // Clock
    initial forever #12.5 aclk = ~aclk;

    // Verdict and end of run
    task automatic end_of_test();
        $display("Compared %0d, failed %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Counting of every comparison
    task automatic tally(input logic ok, input string what);
        tests_run++;
        if (!ok)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tally(got === exp, "register word");
    endtask

    task automatic cmp_pad(input logic [PB_W-1:0] got, input logic [PB_W-1:0] exp);
        tally(got === exp, "pad field");
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        tally(got === exp, "bus response");
    endtask

    // Bounded wait step
    task automatic guard(inout int n);
        n++;
        if (n > 50)
        begin
            tally(1'b0, "handshake timeout");
            end_of_test();
        end
    endtask

    // Register write over the bus
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            guard(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask

    // Register read over the bus
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            guard(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Let pads follow register and pin changes
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask

    // Reset with a given strap setting
    task automatic do_reset(input agm_strap_s s);
        @(posedge aclk);
        aresetn <= 1'b0;
        strap <= s;
        repeat (3) @(posedge aclk);
        cmp_pad(pad_b.oe_n, 4'hF);
        cmp_pad(pad_b.pullup_en, 4'hF);
        aresetn <= 1'b1;
        settle();
    endtask

    // Main sequence
    initial
    begin
        do_reset(3'b100);
        axi_rd(OFS_PB_PERIPH);
        cmp_word(rd, 32'hF);
        foreach (rst_ofs[i])
        begin
            axi_rd(rst_ofs[i]);
            cmp_word(rd, rst_val[i]);
        end
        cmp_pad(pad_b.out, 4'h9);
        cmp_pad(pad_b.oe_n, 4'h0);
        cmp_word({8'h00, pad_a}, 32'h00A5_00FF);
        $display("Test startup done");
        @(posedge aclk);
        emi_bus_active <= 1'b0;
        emi_addr <= 12'h5C3;
        settle();
        cmp_pad(pad_b.oe_n, 4'hF);
        cmp_word({8'h00, pad_a}, 32'h00C3_FFFF);
        axi_wr(OFS_BUS_CTRL, 32'h1);
        cmp_resp(resp, RESP_OKAY);
        settle();
        cmp_pad(pad_b.oe_n, 4'h0);
        cmp_pad(pad_b.out, 4'h5);
        $display("Test address mode done");
        axi_wr(OFS_PB_PERIPH, 32'h0);
        axi_wr(OFS_PB_DIR, 32'h5);
        axi_wr(OFS_PB_DOUT, 32'h3);
        settle();
        cmp_pad(pad_b.oe_n, 4'hA);
        cmp_pad(pad_b.out, 4'h3);
        axi_rd(OFS_PB_DIN);
        cmp_word(rd, 32'hB);
        axi_wr(OFS_PB_PULLUP, 32'hE);
        settle();
        cmp_pad(pad_b.pullup_en, 4'hE);
        $display("Test gpio done");
        axi_rd(8'h3C);
        cmp_resp(resp, RESP_SLVERR);
        cmp_word(rd, 32'h0);
        axi_wr(8'h40, 32'h1);
        cmp_resp(resp, RESP_SLVERR);
        foreach (straps[i])
        begin
            do_reset(straps[i]);
            axi_rd(OFS_PB_PERIPH);
            cmp_word(rd, periph_exp[i]);
        end
        $display("Test errors and straps done");
        end_of_test();
    end
endmodule

// ### dv/agm_ext_mem.sv
`timescale 1ns/10ps
module agm_ext_mem
    import agm_pkg::*;
(
    // Pad controls from the device
    input wire agm_pad_a_s pad_a,
    input wire agm_pad_b_s pad_b,
    // Levels seen back at the pads
    output logic [PA_W-1:0] pa_pin_in = '0,
    output logic [PB_W-1:0] pb_pin_in = '0
);
    // Driven, pulled up, or floating to the inverse of the last level
    always @(pad_a, pad_b)
    begin
        pa_pin_in = (~pad_a.oe_n & pad_a.out) | (pad_a.oe_n & (pad_a.pullup_en | ~pa_pin_in));
        pb_pin_in = (~pad_b.oe_n & pad_b.out) | (pad_b.oe_n & (pad_b.pullup_en | ~pb_pin_in));
    end
endmodule

// ### dv/agm_pin_mux_chk.sv
`timescale 1ns/10ps
module agm_pin_mux_chk
    import agm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pin side
    input wire logic [PA_W+PB_W-1:0] emi_addr,
    input wire agm_strap_s strap,
    input wire agm_pad_b_s pad_b
);
    // Startup choice of the straps
    logic boot_addr;
    assign boot_addr = strap.external_boot_select | (strap.external_memory_mode_select & ~strap.flash_secure);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_pads: assert property (disable iff (1'b0) !aresetn |=> pad_b.oe_n == 4'hF && pad_b.pullup_en == 4'hF)
        else $error("pads not safe in reset");
    chk_reset_bus: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus answer during reset");
    chk_startup_func: assert property ($rose(aresetn) |-> ##2
        pad_b.out == ($past(boot_addr, 2) ? $past(emi_addr[11:8]) : 4'h0))
        else $error("startup function wrong");
    chk_pullup_write: assert property ($changed(pad_b.pullup_en) && $past(aresetn) |-> $past(s_axi_bvalid))
        else $error("pull-up changed without write");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule
bind agm_pin_mux agm_pin_mux_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .emi_addr, .strap, .pad_b);

// ### rtl/agm_pin_mux.sv
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module agm_pin_mux
    import agm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External memory interface side
    input wire logic [PA_W+PB_W-1:0] emi_addr,
    input wire logic emi_bus_active,
    // Startup straps
    input wire agm_strap_s strap,
    // Pads
    input wire logic [PA_W-1:0] pa_pin_in,
    input wire logic [PB_W-1:0] pb_pin_in,
    output agm_pad_a_s pad_a,
    output agm_pad_b_s pad_b
);

    // Byte address is mapped
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            OFS_PA_PULLUP, OFS_PA_DIR, OFS_PA_DOUT, OFS_PA_DIN, OFS_PA_PERIPH,
            OFS_PB_PULLUP, OFS_PB_DIR, OFS_PB_DOUT, OFS_PB_DIN, OFS_PB_PERIPH,
            OFS_BUS_CTRL: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // Register state
    logic [PA_W-1:0] pa_pullup_reg, pa_pullup_next;
    logic [PA_W-1:0] pa_dir_reg, pa_dir_next;
    logic [PA_W-1:0] pa_dout_reg, pa_dout_next;
    logic [PA_W-1:0] pa_din_reg, pa_din_next;
    logic [PA_W-1:0] pa_periph_reg, pa_periph_next;
    logic [PB_W-1:0] pb_pullup_reg, pb_pullup_next;
    logic [PB_W-1:0] pb_dir_reg, pb_dir_next;
    logic [PB_W-1:0] pb_dout_reg, pb_dout_next;
    logic [PB_W-1:0] pb_din_reg, pb_din_next;
    logic [PB_W-1:0] pb_periph_reg, pb_periph_next;
    logic always_drive_reg, always_drive_next;
    logic strap_pending_reg, strap_pending_next;

    // Bus handshake state
    logic aw_hold_reg, aw_hold_next;
    logic w_hold_reg, w_hold_next;
    logic [7:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic arready_reg, arready_next;

    // Pad state
    agm_pad_a_s pad_a_reg, pad_a_next;
    agm_pad_b_s pad_b_reg, pad_b_next;

    logic do_write;
    logic strap_addr_mode;
    logic bus_driven;

    assign do_write = aw_hold_reg && w_hold_reg;
    // Address mode at startup for external boot or unsecured memory mode
    assign strap_addr_mode = strap.external_boot_select ||
        (strap.external_memory_mode_select && !strap.flash_secure);
    // Address lines float while idle unless always-drive is set
    assign bus_driven = always_drive_reg || emi_bus_active;

    // Write channel and register updates
    always_comb
    begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        pa_pullup_next = pa_pullup_reg;
        pa_dir_next = pa_dir_reg;
        pa_dout_next = pa_dout_reg;
        pa_periph_next = pa_periph_reg;
        pb_pullup_next = pb_pullup_reg;
        pb_dir_next = pb_dir_reg;
        pb_dout_next = pb_dout_reg;
        pb_periph_next = pb_periph_reg;
        always_drive_next = always_drive_reg;
        strap_pending_next = 1'b0;
        pa_din_next = pa_pin_in;
        pb_din_next = pb_pin_in;
        // Latch the startup function once after reset release
        if (strap_pending_reg)
        begin
            pb_periph_next = {PB_W{strap_addr_mode}};
        end
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_next = 1'b1;
            waddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        // Commit once both address and data are held
        if (do_write)
        begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = addr_hit(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
            if (wstrb0_reg)
            begin
                case (waddr_reg)
                    OFS_PA_PULLUP: pa_pullup_next = wdata_reg[PA_W-1:0];
                    OFS_PA_DIR: pa_dir_next = wdata_reg[PA_W-1:0];
                    OFS_PA_DOUT: pa_dout_next = wdata_reg[PA_W-1:0];
                    OFS_PA_PERIPH: pa_periph_next = wdata_reg[PA_W-1:0];
                    OFS_PB_PULLUP: pb_pullup_next = wdata_reg[PB_W-1:0];
                    OFS_PB_DIR: pb_dir_next = wdata_reg[PB_W-1:0];
                    OFS_PB_DOUT: pb_dout_next = wdata_reg[PB_W-1:0];
                    OFS_PB_PERIPH: pb_periph_next = wdata_reg[PB_W-1:0];
                    OFS_BUS_CTRL: always_drive_next = wdata_reg[ALWAYS_DRIVE_POS];
                    default: ;
                endcase
            end
        end
        awready_next = !aw_hold_next && !bvalid_next; // Registered ready
        wready_next = !w_hold_next && !bvalid_next; // Registered ready
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            pa_pullup_reg <= RST_PA_PULLUP;
            pa_dir_reg <= RST_PA_DIR;
            pa_dout_reg <= RST_PA_DOUT;
            pa_din_reg <= '0;
            pa_periph_reg <= RST_PA_PERIPH;
            pb_pullup_reg <= RST_PB_PULLUP;
            pb_dir_reg <= RST_PB_DIR;
            pb_dout_reg <= RST_PB_DOUT;
            pb_din_reg <= '0;
            pb_periph_reg <= RST_PB_PERIPH;
            always_drive_reg <= RST_ALWAYS_DRIVE;
            strap_pending_reg <= 1'b1;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
        end
        else
        begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            pa_pullup_reg <= pa_pullup_next;
            pa_dir_reg <= pa_dir_next;
            pa_dout_reg <= pa_dout_next;
            pa_din_reg <= pa_din_next;
            pa_periph_reg <= pa_periph_next;
            pb_pullup_reg <= pb_pullup_next;
            pb_dir_reg <= pb_dir_next;
            pb_dout_reg <= pb_dout_next;
            pb_din_reg <= pb_din_next;
            pb_periph_reg <= pb_periph_next;
            always_drive_reg <= always_drive_next;
            strap_pending_reg <= strap_pending_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
        end
    end

    // Read channel
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_PA_PULLUP: rdata_next[PA_W-1:0] = pa_pullup_reg;
                OFS_PA_DIR: rdata_next[PA_W-1:0] = pa_dir_reg;
                OFS_PA_DOUT: rdata_next[PA_W-1:0] = pa_dout_reg;
                OFS_PA_DIN: rdata_next[PA_W-1:0] = pa_din_reg;
                OFS_PA_PERIPH: rdata_next[PA_W-1:0] = pa_periph_reg;
                OFS_PB_PULLUP: rdata_next[PB_W-1:0] = pb_pullup_reg;
                OFS_PB_DIR: rdata_next[PB_W-1:0] = pb_dir_reg;
                OFS_PB_DOUT: rdata_next[PB_W-1:0] = pb_dout_reg;
                OFS_PB_DIN: rdata_next[PB_W-1:0] = pb_din_reg;
                OFS_PB_PERIPH: rdata_next[PB_W-1:0] = pb_periph_reg;
                OFS_BUS_CTRL: rdata_next[ALWAYS_DRIVE_POS] = always_drive_reg;
                default: ;
            endcase
        end
        arready_next = !rvalid_next; // Registered ready
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
            arready_reg <= 1'b1;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            arready_reg <= arready_next;
        end
    end

    // Pad steering per pin
    always_comb
    begin
        for (int i = 0; i < PA_W; i++)
        begin
            if (pa_periph_reg[i])
            begin
                pad_a_next.out[i] = emi_addr[i];
                pad_a_next.oe_n[i] = !bus_driven;
            end
            else
            begin
                pad_a_next.out[i] = pa_dout_reg[i];
                pad_a_next.oe_n[i] = !pa_dir_reg[i];
            end
        end
        pad_a_next.pullup_en = pa_pullup_reg;
        for (int i = 0; i < PB_W; i++)
        begin
            if (pb_periph_reg[i])
            begin
                pad_b_next.out[i] = emi_addr[PA_W+i];
                pad_b_next.oe_n[i] = !bus_driven;
            end
            else
            begin
                pad_b_next.out[i] = pb_dout_reg[i];
                pad_b_next.oe_n[i] = !pb_dir_reg[i];
            end
        end
        pad_b_next.pullup_en = pb_pullup_reg;
    end

    // Pads in reset: drivers off, pull-ups on
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_a_reg <= '{out: '0, oe_n: '1, pullup_en: '1};
            pad_b_reg <= '{out: '0, oe_n: '1, pullup_en: '1};
        end
        else
        begin
            pad_a_reg <= pad_a_next;
            pad_b_reg <= pad_b_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pad_a = pad_a_reg;
    assign pad_b = pad_b_reg;

endmodule

// ### rtl/agm_pin_mux_unused_placeholder_none.sv
`timescale 1ns/10ps

// ### rtl/agm_pkg.sv
package agm_pkg;

    // Pin counts of the two shared ports
    localparam int PA_W = 8;
    localparam int PB_W = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_PA_PULLUP = 8'h00;
    localparam logic [7:0] OFS_PA_DIR = 8'h04;
    localparam logic [7:0] OFS_PA_DOUT = 8'h08;
    localparam logic [7:0] OFS_PA_DIN = 8'h0C;
    localparam logic [7:0] OFS_PA_PERIPH = 8'h10;
    localparam logic [7:0] OFS_PB_PULLUP = 8'h14;
    localparam logic [7:0] OFS_PB_DIR = 8'h18;
    localparam logic [7:0] OFS_PB_DOUT = 8'h1C;
    localparam logic [7:0] OFS_PB_DIN = 8'h20;
    localparam logic [7:0] OFS_PB_PERIPH = 8'h24;
    localparam logic [7:0] OFS_BUS_CTRL = 8'h28;

    // Field positions
    localparam int ALWAYS_DRIVE_POS = 0;

    // Reset values
    localparam logic [PA_W-1:0] RST_PA_PULLUP = 8'hFF;
    localparam logic [PA_W-1:0] RST_PA_DIR = 8'h00;
    localparam logic [PA_W-1:0] RST_PA_DOUT = 8'h00;
    localparam logic [PA_W-1:0] RST_PA_PERIPH = 8'hFF;
    localparam logic [PB_W-1:0] RST_PB_PULLUP = 4'hF;
    localparam logic [PB_W-1:0] RST_PB_DIR = 4'h0;
    localparam logic [PB_W-1:0] RST_PB_DOUT = 4'h0;
    localparam logic [PB_W-1:0] RST_PB_PERIPH = 4'h0;
    localparam logic RST_ALWAYS_DRIVE = 1'b0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pad control for port A
    typedef struct packed {
        logic [PA_W-1:0] out;
        logic [PA_W-1:0] oe_n;
        logic [PA_W-1:0] pullup_en;
    } agm_pad_a_s;

    // Pad control for port B
    typedef struct packed {
        logic [PB_W-1:0] out;
        logic [PB_W-1:0] oe_n;
        logic [PB_W-1:0] pullup_en;
    } agm_pad_b_s;

    // Startup straps
    typedef struct packed {
        logic external_boot_select;
        logic external_memory_mode_select;
        logic flash_secure;
    } agm_strap_s;

endpackage
